// ### verilog/wdf_pkg.sv
/*
  Constants for the watchdog with oscillator failure detect: register
  offsets, reset values, the unlock keys and the failure count.
  Assumes a 50 MHz system clock and Avalon-MM with 32-bit words.
*/
package wdf_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, index times four)
  // ----------------------------------------------------------------
  localparam logic [11:0] WDF_IDX_OSC_CTRL   = 12'hF86;
  localparam logic [11:0] WDF_IDX_RELOAD_UP  = 12'hFF1;
  localparam logic [11:0] WDF_IDX_RELOAD_MID = 12'hFF2;
  localparam logic [11:0] WDF_IDX_RELOAD_LOW = 12'hFF3;
  localparam logic [11:0] WDF_IDX_WD_CTRL    = 12'hFF0;
  localparam logic [11:0] WDF_IDX_RESET_STAT = 12'hFF4;
  localparam logic [11:0] WDF_IDX_CMD        = 12'hFF5;
  localparam logic [13:0] WDF_ADDR_OSC_CTRL   = {WDF_IDX_OSC_CTRL, 2'b00};
  localparam logic [13:0] WDF_ADDR_RELOAD_UP  = {WDF_IDX_RELOAD_UP, 2'b00};
  localparam logic [13:0] WDF_ADDR_RELOAD_MID = {WDF_IDX_RELOAD_MID, 2'b00};
  localparam logic [13:0] WDF_ADDR_RELOAD_LOW = {WDF_IDX_RELOAD_LOW, 2'b00};
  localparam logic [13:0] WDF_ADDR_WD_CTRL    = {WDF_IDX_WD_CTRL, 2'b00};
  localparam logic [13:0] WDF_ADDR_RESET_STAT = {WDF_IDX_RESET_STAT, 2'b00};
  localparam logic [13:0] WDF_ADDR_CMD        = {WDF_IDX_CMD, 2'b00};

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  WDF_RST_RELOAD_UP  = 8'h00;
  localparam logic [7:0]  WDF_RST_RELOAD_MID = 8'h04;
  localparam logic [7:0]  WDF_RST_RELOAD_LOW = 8'h00;
  localparam logic [7:0]  WDF_RST_OSC_CTRL   = 8'hA0;
  localparam logic [23:0] WDF_COUNT_MAX      = 24'hFFFFFF;
  localparam logic [23:0] WDF_COUNT_ZERO     = 24'h000000;

  // ----------------------------------------------------------------
  // Oscillator control fields
  // ----------------------------------------------------------------
  localparam int WDF_OSC_INT_EN   = 7;
  localparam int WDF_OSC_WD_EN    = 5;
  localparam int WDF_OSC_PFAIL_EN = 4;
  localparam int WDF_OSC_WFAIL_EN = 3;
  localparam logic [2:0] WDF_CLKSEL_WDOSC = 3'h3;

  // Unlock keys
  localparam logic [7:0] WDF_KEY_FIRST  = 8'hE7;
  localparam logic [7:0] WDF_KEY_SECOND = 8'h18;

  // Command register bits
  localparam int WDF_CMD_REFRESH = 0;
  localparam int WDF_CMD_STOP    = 1;

  // Failure detect: system clocks without a watchdog clock edge
  localparam logic [13:0] WDF_FAIL_CYCLES = 14'h1F44;

  // Unlock sequence states
  typedef enum logic [1:0] {
    WDF_LOCKED = 2'b00,
    WDF_HALF   = 2'b01,
    WDF_OPEN   = 2'b10
  } wdf_lock_t;

endpackage : wdf_pkg

// ### verilog/wdf_sync.sv
/*
  Two flip-flop synchroniser for one level.
  Assumes the input is asynchronous to clk.
*/
`timescale 1ns/10ps
module wdf_sync
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);

  logic stage1_q;

  // Second stage is the only reader of the first
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_q <= 1'b0;
      dout     <= 1'b0;
    end
    else
    begin
      stage1_q <= din;
      dout     <= stage1_q;
    end
  end

endmodule : wdf_sync

// ### verilog/wdf_osc_monitor.sv
/*
  Watchdog oscillator failure monitor: counts system clocks between
  edges of the synchronised watchdog clock.
  Assumes wdClkSync is already synchronised to clk.
*/
`timescale 1ns/10ps
module wdf_osc_monitor
  import wdf_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic wdClkSync,
  output logic      wdEdge,
  output logic      failPulse
);

  logic [13:0] cnt_q;
  logic        prev_q;
  logic        edgeSeen;
  logic        limitHit;

  assign edgeSeen = wdClkSync ^ prev_q;
  assign limitHit = (cnt_q == WDF_FAIL_CYCLES - 14'h0001);

  // Count up between edges, flag failure at the limit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_q    <= 1'b0;
      cnt_q     <= 14'h0000;
      wdEdge    <= 1'b0;
      failPulse <= 1'b0;
    end
    else
    begin
      prev_q    <= wdClkSync;
      wdEdge    <= edgeSeen & wdClkSync;
      failPulse <= enable & ~edgeSeen & limitHit;
      if (!enable || edgeSeen || limitHit)
        cnt_q <= 14'h0000;
      else
        cnt_q <= cnt_q + 14'h0001;
    end
  end

endmodule : wdf_osc_monitor

// ### verilog/wdf_watchdog.sv
/*
  Watchdog timer with 24-bit reload, interrupt or reset response,
  stop mode wake, watchdog oscillator failure detection and a lockable
  oscillator control register, reached over Avalon-MM.
  Assumes wdClk is a free slow clock pin; the core drives refresh and
  stop through the command register or the refreshIn and stopIn pins.
*/
`timescale 1ns/10ps

// How it works
// - Interrupt-mode time-out in stop mode starts recovery and raises interrupt request.
// - Interrupt-mode time-out in stop mode sets watchdog status and stop bits to one.
// - In stop mode, interrupt request is presented only once stop recovery has completed.
// - Reload value is 24 bits over upper, middle and lower byte registers.
// - Reading a reload byte returns the count byte; writing sets the reload byte.
// - After reset the middle reload byte is 04H, others zero.
// - Watchdog oscillator failure raises a non-maskable event, no clock switch.
// - After watchdog oscillator failure, primary oscillator failure detection is disabled.
// - Failure declared after 8004 system clocks without a watchdog clock edge.
// - Oscillator control accepts a write only after E7H then 18H.
// - Oscillator control relocks after one successful write.
// - Oscillator control holds oscillator enables, fail enables and clock select.
// - Failure detect and all clocks disabled halts device until power-on reset.
// - When first enabled the counter loads reload and counts down to zero.
// - Refresh reloads the counter with the reload value, then counting resumes.
// - At zero the watchdog gives interrupt or reset per the option bit.
// - After an interrupt time-out the counter rolls to maximum and continues.
module wdf_watchdog
  import wdf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [13:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [1:0]       avs_response,
  input  wire logic        wdClk,
  input  wire logic        timeoutResetSelectOption,
  input  wire logic        refreshIn,
  input  wire logic        stopIn,
  input  wire logic        primaryFailIn,
  output logic             wdIrq_q,
  output logic             wdResetReq_q,
  output logic             stopRecovery_q,
  output logic             oscFailEvent_q,
  output logic             primaryFailEvent_q,
  output logic             deviceHalt_q
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [23:0] reload_q;
  logic [23:0] count_q;
  logic [7:0]  oscCtrl_q;
  wdf_lock_t   lock_q;
  logic        started_q;
  logic        timeoutFlag_q;
  logic        stopFlag_q;
  logic        stopMode_q;
  logic        wdFailed_q;
  logic        ackPend_q;
  logic        recoverPend_q;
  logic        refreshPin;
  logic        stopPin;
  logic        primFailPin;
  logic        wdClkSync;
  logic        wdEdge;
  logic        failPulse;

  // Pins from outside pass two flip-flops
  wdf_sync uSyncWd   (.clk(clk), .rst_n(rst_n), .din(wdClk),         .dout(wdClkSync));
  wdf_sync uSyncRef  (.clk(clk), .rst_n(rst_n), .din(refreshIn),     .dout(refreshPin));
  wdf_sync uSyncStop (.clk(clk), .rst_n(rst_n), .din(stopIn),        .dout(stopPin));
  wdf_sync uSyncPf   (.clk(clk), .rst_n(rst_n), .din(primaryFailIn), .dout(primFailPin));

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic accessGo;
  logic wrGo;
  logic rdGo;
  logic lane0;
  logic hitOsc;
  logic hitUp;
  logic hitMid;
  logic hitLow;
  logic hitWdc;
  logic hitRst;
  logic hitCmd;
  logic hitAny;
  logic [7:0] wrByte;

  // One wait cycle per access: answer on the second edge
  assign accessGo = (avs_read | avs_write) & ackPend_q;
  assign wrGo     = accessGo & avs_write & lane0;
  assign rdGo     = accessGo & avs_read;
  assign lane0    = avs_byteenable[0];
  assign wrByte   = avs_writedata[7:0];
  assign hitOsc   = (avs_address == WDF_ADDR_OSC_CTRL);
  assign hitUp    = (avs_address == WDF_ADDR_RELOAD_UP);
  assign hitMid   = (avs_address == WDF_ADDR_RELOAD_MID);
  assign hitLow   = (avs_address == WDF_ADDR_RELOAD_LOW);
  assign hitWdc   = (avs_address == WDF_ADDR_WD_CTRL);
  assign hitRst   = (avs_address == WDF_ADDR_RESET_STAT);
  assign hitCmd   = (avs_address == WDF_ADDR_CMD);
  assign hitAny   = hitOsc | hitUp | hitMid | hitLow | hitWdc | hitRst | hitCmd;

  // ----------------------------------------------------------------
  // Counter control
  // ----------------------------------------------------------------
  logic wdEnabled;
  logic cmdRefresh;
  logic cmdStop;
  logic doRefresh;
  logic atZero;
  logic timeout;
  logic statusRead;

  assign wdEnabled  = oscCtrl_q[WDF_OSC_WD_EN];
  assign cmdRefresh = wrGo & hitCmd & wrByte[WDF_CMD_REFRESH];
  assign cmdStop    = wrGo & hitCmd & wrByte[WDF_CMD_STOP];
  assign doRefresh  = cmdRefresh | refreshPin;
  assign atZero     = (count_q == WDF_COUNT_ZERO);
  assign timeout    = started_q & wdEdge & atZero;
  assign statusRead = rdGo & hitRst;

  // ----------------------------------------------------------------
  // Oscillator control write with unlock
  // ----------------------------------------------------------------
  logic      oscWr;
  logic      oscCommit;
  wdf_lock_t lock_d;

  assign oscWr     = wrGo & hitOsc;
  assign oscCommit = oscWr & (lock_q == WDF_OPEN);
  assign lock_d    = !oscWr                                  ? lock_q     :
                     (lock_q == WDF_LOCKED && wrByte == WDF_KEY_FIRST)  ? WDF_HALF   :
                     (lock_q == WDF_HALF && wrByte == WDF_KEY_SECOND)   ? WDF_OPEN   :
                     WDF_LOCKED;

  // Register stores and the lock state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reload_q  <= {WDF_RST_RELOAD_UP, WDF_RST_RELOAD_MID, WDF_RST_RELOAD_LOW};
      oscCtrl_q <= WDF_RST_OSC_CTRL;
      lock_q    <= WDF_LOCKED;
    end
    else
    begin
      lock_q <= lock_d;
      if (oscCommit)
        oscCtrl_q <= wrByte;
      if (wrGo && hitUp)
        reload_q[23:16] <= wrByte;
      if (wrGo && hitMid)
        reload_q[15:8] <= wrByte;
      if (wrGo && hitLow)
        reload_q[7:0] <= wrByte;
    end
  end

  // Down counter, stepped by the watchdog clock
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q   <= WDF_COUNT_MAX;
      started_q <= 1'b0;
    end
    else if (!wdEnabled)
      started_q <= 1'b0;
    else if (!started_q || doRefresh)
    begin
      count_q   <= reload_q;
      started_q <= 1'b1;
    end
    else if (wdEdge)
      count_q <= count_q - 24'h000001;                             // wraps to max
  end

  // Time-out response, stop mode, status flags
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timeoutFlag_q  <= 1'b0;
      stopFlag_q     <= 1'b0;
      stopMode_q     <= 1'b0;
      recoverPend_q  <= 1'b0;
      wdIrq_q        <= 1'b0;
      wdResetReq_q   <= 1'b0;
      stopRecovery_q <= 1'b0;
    end
    else
    begin
      wdResetReq_q   <= timeout & timeoutResetSelectOption;
      stopRecovery_q <= timeout & ~timeoutResetSelectOption & stopMode_q;
      if (timeout && !timeoutResetSelectOption)
        timeoutFlag_q <= 1'b1;                                     // set wins over clear
      else if (statusRead)
        timeoutFlag_q <= 1'b0;
      if (timeout && !timeoutResetSelectOption && stopMode_q)
        stopFlag_q <= 1'b1;
      else if (statusRead)
        stopFlag_q <= 1'b0;
      if (timeout && !timeoutResetSelectOption && stopMode_q)
        stopMode_q <= 1'b0;
      else if (cmdStop || stopPin)
        stopMode_q <= 1'b1;
      // Recovery marker lasts one cycle only, so a held stop pin
      // cannot pin the request high against the status read clear
      recoverPend_q <= timeout & ~timeoutResetSelectOption & stopMode_q;
      // Request shows at once outside stop mode, after recovery completes in stop mode, drops on the status read
      if (timeout && !timeoutResetSelectOption && !stopMode_q)
        wdIrq_q <= 1'b1;
      else if (recoverPend_q)
        wdIrq_q <= 1'b1;
      else if (statusRead)
        wdIrq_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Failure detection
  // ----------------------------------------------------------------
  logic detectOn;

  assign detectOn = oscCtrl_q[WDF_OSC_WFAIL_EN] & ~wdFailed_q;

  wdf_osc_monitor uMon
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .enable    (detectOn),
    .wdClkSync (wdClkSync),
    .wdEdge    (wdEdge),
    .failPulse (failPulse)
  );

  // Failure events and halt
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wdFailed_q         <= 1'b0;
      oscFailEvent_q     <= 1'b0;
      primaryFailEvent_q <= 1'b0;
      deviceHalt_q       <= 1'b0;
    end
    else
    begin
      oscFailEvent_q <= failPulse;                                 // no switch-over
      if (failPulse)
        wdFailed_q <= 1'b1;
      primaryFailEvent_q <= primFailPin & oscCtrl_q[WDF_OSC_PFAIL_EN] & ~wdFailed_q;
      if (!oscCtrl_q[WDF_OSC_INT_EN] && !oscCtrl_q[WDF_OSC_WD_EN] &&
          !oscCtrl_q[WDF_OSC_PFAIL_EN] && !oscCtrl_q[WDF_OSC_WFAIL_EN])
        deviceHalt_q <= 1'b1;                                      // only reset clears
    end
  end

  // ----------------------------------------------------------------
  // Read mux and bus answer
  // ----------------------------------------------------------------
  logic [7:0] rdByte;

  assign rdByte = hitUp  ? count_q[23:16] :
                  hitMid ? count_q[15:8]  :
                  hitLow ? count_q[7:0]   :
                  hitOsc ? oscCtrl_q      :
                  hitWdc ? {timeoutFlag_q, stopFlag_q, 6'h00} :
                  hitRst ? {timeoutFlag_q, stopFlag_q, wdFailed_q, 5'h00} :
                  8'h00;

  // Waitrequest high one cycle, then answer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ackPend_q       <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      avs_response    <= 2'b00;
    end
    else
    begin
      ackPend_q       <= (avs_read | avs_write) & ~ackPend_q;
      avs_waitrequest <= ~((avs_read | avs_write) & ~ackPend_q);
      avs_response    <= ((avs_read | avs_write) & ~hitAny) ? 2'b11 : 2'b00;
      if (avs_read && !ackPend_q)
        avs_readdata <= {24'h000000, rdByte};
    end
  end

endmodule : wdf_watchdog

// ### dv/wdf_watchdog_chk.sv
/*
  Checker for wdf_watchdog: bus wait timing, time-out responses,
  failure timing and halt. Sees only the top module's ports.
*/
`timescale 1ns/10ps
module wdf_watchdog_chk
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        wdClk,
  input wire logic        timeoutResetSelectOption,
  input wire logic        wdIrq_q,
  input wire logic        wdResetReq_q,
  input wire logic        stopRecovery_q,
  input wire logic        oscFailEvent_q,
  input wire logic        primaryFailEvent_q,
  input wire logic        deviceHalt_q
);
  logic [13:0] idleCnt_q;
  logic        wdPrev_q;
  logic [1:0]  failAge_q;

  // ----
  // Helpers
  // ----
  // Cycles since the watchdog clock pin changed; age after a failure
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idleCnt_q <= 14'h0000;
      wdPrev_q  <= 1'b0;
      failAge_q <= 2'h0;
    end
    else
    begin
      wdPrev_q <= wdClk;
      if (wdClk != wdPrev_q)
        idleCnt_q <= 14'h0000;
      else if (idleCnt_q != 14'h3FFF)
        idleCnt_q <= idleCnt_q + 14'h0001;
      if (failAge_q != 2'h3 && (oscFailEvent_q || failAge_q != 2'h0))
        failAge_q <= failAge_q + 2'h1;
    end
  end

  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait cycle");
  a_wait_drop: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_data_byte: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("read data above the low byte not zero");
  a_wake_irq: assert property ($rose(stopRecovery_q) && !timeoutResetSelectOption |=> $rose(wdIrq_q))
    else $error("no interrupt after stop recovery");
  a_irq_mode: assert property (timeoutResetSelectOption |-> !$rose(wdIrq_q))
    else $error("interrupt raised in reset response mode");
  a_reset_mode: assert property (!timeoutResetSelectOption |-> !$rose(wdResetReq_q))
    else $error("reset request in interrupt response mode");
  a_fail_pulse: assert property (oscFailEvent_q |=> !oscFailEvent_q)
    else $error("failure event longer than one cycle");
  a_fail_time: assert property ($rose(oscFailEvent_q) |-> idleCnt_q >= 14'h1F44 && idleCnt_q <= 14'h1F54)
    else $error("failure event at wrong idle count");
  a_no_primary: assert property (failAge_q == 2'h3 |-> !primaryFailEvent_q)
    else $error("primary failure reported after watchdog failure");
  a_halt_hold: assert property (deviceHalt_q |=> deviceHalt_q)
    else $error("halt released without reset");
endmodule : wdf_watchdog_chk

bind wdf_watchdog wdf_watchdog_chk i_chk (.clk(clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wdClk(wdClk),
  .timeoutResetSelectOption(timeoutResetSelectOption), .wdIrq_q(wdIrq_q), .wdResetReq_q(wdResetReq_q),
  .stopRecovery_q(stopRecovery_q), .oscFailEvent_q(oscFailEvent_q), .primaryFailEvent_q(primaryFailEvent_q),
  .deviceHalt_q(deviceHalt_q));

// ### dv/tb_wdf_watchdog.sv
/*
  Self-checking bench for wdf_watchdog: registers, unlock, countdown,
  time-out responses, failure detect and halt.
  Assumes wdf_pkg and the checker are compiled first.
*/
`timescale 1ns/10ps
module tb_wdf_watchdog;
  import wdf_pkg::*;

  logic        clk, rst_n, avsRead, avsWrite, wdClk, optRst, refreshIn, stopIn, primaryFailIn;
  logic [13:0] avsAddr;
  logic [3:0]  avsBe;
  logic [31:0] avsWdata, avsRdata, rdQ;
  logic [1:0]  avsResp, respQ;
  logic        avsWait, wdIrq, wdRst, wake, oscFail, primFail, halt;
  int          checks = 0, badCount = 0, nRst = 0, nWake = 0, nFail = 0, cyc = 0;

  wdf_watchdog i_wdf_watchdog (.clk(clk), .rst_n(rst_n), .avs_address(avsAddr), .avs_read(avsRead),
    .avs_write(avsWrite), .avs_writedata(avsWdata), .avs_byteenable(avsBe), .avs_readdata(avsRdata),
    .avs_waitrequest(avsWait), .avs_response(avsResp), .wdClk(wdClk), .timeoutResetSelectOption(optRst),
    .refreshIn(refreshIn), .stopIn(stopIn), .primaryFailIn(primaryFailIn), .wdIrq_q(wdIrq),
    .wdResetReq_q(wdRst), .stopRecovery_q(wake), .oscFailEvent_q(oscFail), .primaryFailEvent_q(primFail),
    .deviceHalt_q(halt));

  // ----
  // Clock, pulse counters, run limit
  // ----
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    nRst  <= nRst + int'(wdRst === 1'b1);
    nWake <= nWake + int'(wake === 1'b1);
    nFail <= nFail + int'(oscFail === 1'b1);
    cyc   <= cyc + 1;
    if (cyc == 40000)
    begin
      badCount++;
      reportAndStop();
    end
  end

  task automatic reportAndStop;
    $display("checks %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : reportAndStop

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [13:0] a, input logic [7:0] d);
    @(posedge clk);
    avsAddr  <= a;
    avsWdata <= {24'h000000, d};
    avsRead  <= ~w;
    avsWrite <= w;
    @(posedge clk);
    while (avsWait !== 1'b0)
      @(posedge clk);
    rdQ      = avsRdata;
    respQ    = avsResp;
    avsRead  <= 1'b0;
    avsWrite <= 1'b0;
  endtask : bus

  task automatic rdc(input string nm, input logic [13:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, {24'h000000, e}, rdQ & {24'hFFFFFF, m});
  endtask : rdc

  task automatic oscw(input logic [7:0] v);
    bus(1'b1, WDF_ADDR_OSC_CTRL, 8'hE7);
    bus(1'b1, WDF_ADDR_OSC_CTRL, 8'h18);
    bus(1'b1, WDF_ADDR_OSC_CTRL, v);
  endtask : oscw

  task automatic tick(input int n);
    repeat (n)
    begin
      wdClk <= 1'b1;
      repeat (10) @(posedge clk);
      wdClk <= 1'b0;
      repeat (10) @(posedge clk);
    end
  endtask : tick

  task automatic refresh;
    refreshIn <= 1'b1;
    repeat (5) @(posedge clk);
    refreshIn <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : refresh

  // ----
  // Scenarios
  // ----
  task automatic tResetLock;
    rdc("osc reset", WDF_ADDR_OSC_CTRL, 8'hFF, 8'hA0);
    bus(1'b0, 14'h0000, 8'h00);
    chk("unmapped resp", 32'h00000003, {30'h00000000, respQ});
    oscw(8'h80);
    oscw(8'hA0);
    rdc("reload upper", WDF_ADDR_RELOAD_UP, 8'hFF, 8'h00);
    rdc("reload middle", WDF_ADDR_RELOAD_MID, 8'hFF, 8'h04);
    rdc("reload lower", WDF_ADDR_RELOAD_LOW, 8'hFF, 8'h00);
    oscw(8'hB0);
    rdc("osc unlocked", WDF_ADDR_OSC_CTRL, 8'hFF, 8'hB0);
    bus(1'b1, WDF_ADDR_OSC_CTRL, 8'h20);
    rdc("osc relocked", WDF_ADDR_OSC_CTRL, 8'hFF, 8'hB0);
    bus(1'b1, WDF_ADDR_OSC_CTRL, 8'hE7);
    bus(1'b1, WDF_ADDR_OSC_CTRL, 8'h55);
    bus(1'b1, WDF_ADDR_OSC_CTRL, 8'h18);
    bus(1'b1, WDF_ADDR_OSC_CTRL, 8'hA0);
    rdc("osc broken key", WDF_ADDR_OSC_CTRL, 8'hFF, 8'hB0);
    primaryFailIn <= 1'b1;
    repeat (8) @(posedge clk);
    chk("primary fail", 32'h00000001, {31'h00000000, primFail});
    primaryFailIn <= 1'b0;
  endtask : tResetLock

  task automatic tCount;
    bus(1'b1, WDF_ADDR_RELOAD_LOW, 8'h03);
    bus(1'b1, WDF_ADDR_RELOAD_MID, 8'h00);
    // Write with lane 0 disabled must leave the reload byte alone
    avsBe <= 4'hE;
    bus(1'b1, WDF_ADDR_RELOAD_LOW, 8'h7F);
    avsBe <= 4'hF;
    refresh();
    rdc("count low", WDF_ADDR_RELOAD_LOW, 8'hFF, 8'h03);
    rdc("count mid", WDF_ADDR_RELOAD_MID, 8'hFF, 8'h00);
    tick(1);
    rdc("count step", WDF_ADDR_RELOAD_LOW, 8'hFF, 8'h02);
    tick(3);
    chk("irq", 32'h00000001, {31'h00000000, wdIrq});
    rdc("wrap upper", WDF_ADDR_RELOAD_UP, 8'hFF, 8'hFF);
    rdc("wrap lower", WDF_ADDR_RELOAD_LOW, 8'hFF, 8'hFF);
    rdc("status flag", WDF_ADDR_RESET_STAT, 8'h80, 8'h80);
    repeat (3) @(posedge clk);
    chk("irq cleared", 32'h00000000, {31'h00000000, wdIrq});
  endtask : tCount

  task automatic tResetMode;
    optRst <= 1'b1;
    refresh();
    tick(4);
    chk("reset pulses", 32'h00000001, nRst);
    chk("irq reset mode", 32'h00000000, {31'h00000000, wdIrq});
    optRst <= 1'b0;
    bus(1'b0, WDF_ADDR_RESET_STAT, 8'h00);
  endtask : tResetMode

  task automatic tStop;
    bus(1'b1, WDF_ADDR_CMD, 8'h03); // Refresh and enter stop
    stopIn <= 1'b1;
    tick(4);
    chk("wake pulses", 32'h00000001, nWake);
    chk("irq after wake", 32'h00000001, {31'h00000000, wdIrq});
    rdc("ctrl flags", WDF_ADDR_WD_CTRL, 8'hC0, 8'hC0);
    stopIn <= 1'b0;
    bus(1'b0, WDF_ADDR_RESET_STAT, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq wake cleared", 32'h00000000, {31'h00000000, wdIrq});
  endtask : tStop

  task automatic tFail;
    oscw(8'hB8);
    tick(2);
    repeat (7990) @(posedge clk);
    chk("fail early", 32'h00000000, nFail);
    repeat (40) @(posedge clk);
    chk("fail event", 32'h00000001, nFail);
    primaryFailIn <= 1'b1;
    repeat (8) @(posedge clk);
    chk("primary after", 32'h00000000, {31'h00000000, primFail});
  endtask : tFail

  task automatic tHalt;
    chk("no halt", 32'h00000000, {31'h00000000, halt});
    oscw(8'h00); // fail detect off along with the oscillator
    repeat (5) @(posedge clk);
    chk("halt", 32'h00000001, {31'h00000000, halt});
  endtask : tHalt

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsAddr = 14'h0000;
    avsBe = 4'hF;
    avsWdata = 32'h00000000;
    wdClk = 1'b0;
    optRst = 1'b0;
    refreshIn = 1'b0;
    stopIn = 1'b0;
    primaryFailIn = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    tResetLock();
    tCount();
    tResetMode();
    tStop();
    tFail();
    tHalt();
    reportAndStop();
  end
endmodule : tb_wdf_watchdog
